// ### hdl/tsr_register_map.v
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_register_map #(
  parameter DUAL = 1,
  parameter [6:0] DEV_ADDR = 7'h4C,
  parameter [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter [7:0] PART_ID = 8'h0D // arbitrary value
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // two-wire serial bus, open drain
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // converter results, same clock
  input wire conv_busy,
  input wire result_valid,
  input wire [1:0] result_chan,
  input wire signed [15:0] result_temp,
  input wire result_not_valid_flag,
  input wire result_open_flag,
  // controls to the converter
  output wire shutdown_request_bit,
  output wire range_extended,
  output wire [7:0] channel_enable_cfg,
  output wire [7:0] conv_rate,
  output wire [7:0] beta_range,
  output wire [7:0] ideality_1,
  output wire [7:0] ideality_2,
  output wire one_shot_pulse,
  output wire soft_reset_pulse
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_WRX = 3'h3;
  localparam [2:0] ST_RTX = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;

  localparam [7:0] CFG2_RST = DUAL ? `TSR_RST_CFG2_DUAL : `TSR_RST_CFG2_SINGLE;
  localparam [7:0] CFG2_MASK = DUAL ? `TSR_MASK_CFG2_DUAL : `TSR_MASK_CFG2_SINGLE;
  localparam [7:0] BETA_RST = DUAL ? `TSR_RST_BETA_DUAL : `TSR_RST_BETA_SINGLE;
  localparam [7:0] BETA_MASK = DUAL ? `TSR_MASK_BETA_DUAL : `TSR_MASK_BETA_SINGLE;

  // ==========================================================
  // conversion encoding
  // result in sixteenths of a degree to {high byte, fraction nibble}
  function [11:0] encode;
    input signed [15:0] t;
    input ext;
    reg signed [16:0] v;
    begin
      v = {t[15], t};
      if (ext) begin
        v = v + `TSR_EXT_OFFSET;
        if (v < `TSR_EXT_MIN) begin
          v = `TSR_EXT_MIN;
        end else if (v > `TSR_EXT_MAX) begin
          v = `TSR_EXT_MAX;
        end
      end else begin
        if (v < `TSR_STD_MIN) begin
          v = `TSR_STD_MIN;
        end else if (v > `TSR_STD_MAX) begin
          v = `TSR_STD_MAX;
        end
      end
      // floor split: fraction stays unsigned and adds to the high byte
      encode = v[11:0];
    end
  endfunction

  // true for the high-byte pointers of existing channels, 02 only on the dual variant
  function is_high_ptr;
    input [7:0] p;
    begin
      is_high_ptr = (p == `TSR_PTR_LOCAL_HIGH) || (p == `TSR_PTR_REM1_HIGH) ||
                    ((p == `TSR_PTR_REM2_HIGH) && (DUAL != 0));
    end
  endfunction

  // ==========================================================
  // pin synchronisers and glitch filter
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg scl_f_reg;
  reg sda_f_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  wire scl_rise = scl_f_reg & ~scl_d_reg;
  wire scl_fall = ~scl_f_reg & scl_d_reg;
  wire bus_start = scl_f_reg & scl_d_reg & ~sda_f_reg & sda_d_reg;
  wire bus_stop = scl_f_reg & scl_d_reg & sda_f_reg & ~sda_d_reg;

  // a level counts only once stages two and three agree
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_f_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_f_reg <= sda_sync_reg[2];
      end
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
    end
  end

  // ==========================================================
  // register storage
  reg [7:0] ptr_reg;
  reg [7:0] cfg1_reg;
  reg [7:0] cfg2_reg;
  reg [7:0] rate_reg;
  reg [7:0] beta_reg;
  reg [7:0] nc1_reg;
  reg [7:0] nc2_reg;
  reg [7:0] high_reg [0:2];
  reg [7:0] low_reg [0:2];
  reg range_act_reg;
  reg busy_d_reg;
  reg one_shot_reg;
  reg soft_rst_reg;
  reg [7:0] shadow_low_reg;
  reg [7:0] shadow_ptr_reg;
  reg shadow_ok_reg;

  // ==========================================================
  // serial bus engine state
  reg [2:0] state_reg;
  reg [2:0] bitcnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [7:0] rd_ptr_reg;
  reg rw_reg;
  reg first_reg;
  reg full_reg;
  reg mack_reg;
  reg oe_reg;
  reg sda_out_reg;

  // write strobe into the register file, decoded from the engine
  reg wr_en;
  reg [7:0] wr_ptr;
  reg [7:0] wr_data;
  reg rd_load;

  // ==========================================================
  // read multiplexer with the low-byte snapshot
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `TSR_RST_ZERO;
    if (rd_ptr_reg == `TSR_PTR_LOCAL_HIGH) begin
      rd_byte = high_reg[0];
    end else if (rd_ptr_reg == `TSR_PTR_REM1_HIGH) begin
      rd_byte = high_reg[1];
    end else if ((rd_ptr_reg == `TSR_PTR_REM2_HIGH) && (DUAL != 0)) begin
      rd_byte = high_reg[2];
    end else if (rd_ptr_reg == `TSR_PTR_STATUS) begin
      rd_byte = {conv_busy, 7'h00};
    end else if (rd_ptr_reg == `TSR_PTR_CFG1) begin
      rd_byte = cfg1_reg;
    end else if (rd_ptr_reg == `TSR_PTR_CFG2) begin
      rd_byte = cfg2_reg;
    end else if (rd_ptr_reg == `TSR_PTR_RATE) begin
      rd_byte = rate_reg;
    end else if (rd_ptr_reg == `TSR_PTR_BETA) begin
      rd_byte = beta_reg;
    end else if (shadow_ok_reg && (rd_ptr_reg == shadow_ptr_reg)) begin
      rd_byte = shadow_low_reg;
    end else if (rd_ptr_reg == `TSR_PTR_LOCAL_LOW) begin
      rd_byte = low_reg[0];
    end else if (rd_ptr_reg == `TSR_PTR_REM1_LOW) begin
      rd_byte = low_reg[1];
    end else if ((rd_ptr_reg == `TSR_PTR_REM2_LOW) && (DUAL != 0)) begin
      rd_byte = low_reg[2];
    end else if (rd_ptr_reg == `TSR_PTR_NC1) begin
      rd_byte = nc1_reg;
    end else if ((rd_ptr_reg == `TSR_PTR_NC2) && (DUAL != 0)) begin
      rd_byte = nc2_reg;
    end else if (rd_ptr_reg == `TSR_PTR_MAKER_ID) begin
      rd_byte = MAKER_ID;
    end else if (rd_ptr_reg == `TSR_PTR_PART_ID) begin
      rd_byte = PART_ID;
    end
  end

  // ==========================================================
  // serial bus engine: sample on scl rise, drive on scl fall
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rd_ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      full_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      wr_en <= 1'b0;
      wr_ptr <= 8'h00;
      wr_data <= 8'h00;
      rd_load <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      rd_load <= 1'b0;
      sda_out_reg <= 1'b0; // open drain only ever pulls low
      // after a high byte the next byte is its low byte
      if (rd_load && is_high_ptr(rd_ptr_reg)) begin
        rd_ptr_reg <= rd_ptr_reg | `TSR_PTR_LOW_SEL;
      end
      if (bus_start) begin
        // repeated start is handled like a fresh one
        state_reg <= ST_ADDR;
        bitcnt_reg <= 3'h0;
        full_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_WRX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_f_reg};
              bitcnt_reg <= bitcnt_reg + 3'h1;
              full_reg <= (bitcnt_reg == `TSR_LAST_BIT);
            end else if (scl_fall && full_reg) begin
              full_reg <= 1'b0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  rw_reg <= shift_reg[0];
                  first_reg <= ~shift_reg[0];
                  rd_ptr_reg <= ptr_reg;
                  oe_reg <= 1'b1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                // first data byte of a write is the pointer, later ones data
                wr_en <= 1'b1;
                wr_ptr <= first_reg ? `TSR_PTR_SOFT_RESET : ptr_reg;
                wr_data <= shift_reg;
                first_reg <= 1'b0;
                oe_reg <= 1'b1;
                state_reg <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt_reg <= 3'h0;
              if (rw_reg) begin
                tx_reg <= rd_byte;
                oe_reg <= ~rd_byte[7];
                rd_load <= 1'b1;
                state_reg <= ST_RTX;
              end else begin
                oe_reg <= 1'b0;
                state_reg <= ST_WRX;
              end
            end
          end
          ST_RTX: begin
            if (scl_rise) begin
              bitcnt_reg <= bitcnt_reg + 3'h1;
              full_reg <= (bitcnt_reg == `TSR_LAST_BIT);
            end else if (scl_fall) begin
              if (full_reg) begin
                full_reg <= 1'b0;
                oe_reg <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                oe_reg <= ~tx_reg[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_f_reg;
            end else if (scl_fall) begin
              if (mack_reg) begin
                bitcnt_reg <= 3'h0;
                tx_reg <= rd_byte;
                oe_reg <= ~rd_byte[7];
                rd_load <= 1'b1;
                state_reg <= ST_RTX;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // pointer, configuration and results
  // pointer writes use a flag so the soft-reset pointer alias is never stored
  reg ptr_wr;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_wr <= 1'b0;
    end else begin
      ptr_wr <= scl_fall && full_reg && (state_reg == ST_WRX) && first_reg && !bus_start &&
                !bus_stop;
    end
  end

  // one encoding feeds both bytes
  wire [11:0] enc_res = encode(result_temp, range_act_reg);

  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= `TSR_RST_ZERO;
      cfg1_reg <= `TSR_RST_ZERO;
      cfg2_reg <= CFG2_RST;
      rate_reg <= `TSR_RST_RATE;
      beta_reg <= BETA_RST;
      nc1_reg <= `TSR_RST_ZERO;
      nc2_reg <= `TSR_RST_ZERO;
      for (i = 0; i < 3; i = i + 1) begin
        high_reg[i] <= `TSR_RST_ZERO;
        low_reg[i] <= `TSR_RST_ZERO;
      end
      range_act_reg <= 1'b0;
      busy_d_reg <= 1'b0;
      one_shot_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      shadow_low_reg <= `TSR_RST_ZERO;
      shadow_ptr_reg <= `TSR_RST_ZERO;
      shadow_ok_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      // software reset returns the file to its power-on contents
      ptr_reg <= `TSR_RST_ZERO;
      cfg1_reg <= `TSR_RST_ZERO;
      cfg2_reg <= CFG2_RST;
      rate_reg <= `TSR_RST_RATE;
      beta_reg <= BETA_RST;
      nc1_reg <= `TSR_RST_ZERO;
      nc2_reg <= `TSR_RST_ZERO;
      for (i = 0; i < 3; i = i + 1) begin
        high_reg[i] <= `TSR_RST_ZERO;
        low_reg[i] <= `TSR_RST_ZERO;
      end
      range_act_reg <= 1'b0;
      busy_d_reg <= conv_busy;
      one_shot_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      shadow_ok_reg <= 1'b0;
    end else begin
      busy_d_reg <= conv_busy;
      one_shot_reg <= 1'b0;
      // format is frozen at conversion start so a running one keeps its range
      if (conv_busy && !busy_d_reg) begin
        range_act_reg <= cfg1_reg[`TSR_BIT_RANGE];
      end
      if (ptr_wr) begin
        ptr_reg <= wr_data;
      end else if (wr_en) begin
        if (wr_ptr == `TSR_PTR_CFG1) begin
          cfg1_reg <= wr_data & `TSR_MASK_CFG1;
        end else if (wr_ptr == `TSR_PTR_CFG2) begin
          cfg2_reg <= wr_data & CFG2_MASK;
        end else if (wr_ptr == `TSR_PTR_RATE) begin
          rate_reg <= wr_data & `TSR_MASK_RATE;
        end else if (wr_ptr == `TSR_PTR_BETA) begin
          beta_reg <= wr_data & BETA_MASK;
        end else if (wr_ptr == `TSR_PTR_NC1) begin
          nc1_reg <= wr_data;
        end else if ((wr_ptr == `TSR_PTR_NC2) && (DUAL != 0)) begin
          nc2_reg <= wr_data;
        end else if (wr_ptr == `TSR_PTR_ONE_SHOT) begin
          // ignored while a conversion runs; only meaningful in shutdown
          one_shot_reg <= cfg1_reg[`TSR_BIT_SHUTDOWN] & ~conv_busy;
        end else if (wr_ptr == `TSR_PTR_SOFT_RESET) begin
          soft_rst_reg <= 1'b1;
        end
      end
      // a finished conversion updates one channel's byte pair together
      if (result_valid && ((result_chan != `TSR_CH_REM2) || (DUAL != 0)) &&
          (result_chan <= `TSR_CH_REM2)) begin
        high_reg[result_chan] <= enc_res[11:4];
        low_reg[result_chan] <= {enc_res[3:0], 2'b00,
                                 result_not_valid_flag,
                                 result_open_flag & (result_chan != `TSR_CH_LOCAL)};
      end
      // every byte handed to the bus either arms or drops the snapshot
      if (rd_load) begin
        if (is_high_ptr(rd_ptr_reg)) begin
          shadow_low_reg <= low_reg[rd_ptr_reg[1:0]];
          shadow_ptr_reg <= rd_ptr_reg | `TSR_PTR_LOW_SEL;
          shadow_ok_reg <= 1'b1;
        end else begin
          shadow_ok_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign sda_out = sda_out_reg;
  assign sda_oe = oe_reg;
  assign shutdown_request_bit = cfg1_reg[`TSR_BIT_SHUTDOWN];
  assign range_extended = range_act_reg;
  assign channel_enable_cfg = cfg2_reg;
  assign conv_rate = rate_reg;
  assign beta_range = beta_reg;
  assign ideality_1 = nc1_reg;
  assign ideality_2 = nc2_reg;
  assign one_shot_pulse = one_shot_reg;
  assign soft_reset_pulse = soft_rst_reg;

endmodule

// ### hdl/tsr_defines.vh
// Contract
// - each channel stores two bytes; high byte holds whole degrees, one per count
// - low byte holds the fraction at a fixed sixteenth of a degree per count
// - fraction sits left-justified in low bits 7..4; bits 3..0 carry no weight
// - standard format encodes the high byte as signed two's complement
// - extended format encodes the high byte unsigned with a minus 64 degree offset
// - fraction is unsigned and adds to the high byte, also for negative values
// - an eight-bit pointer selects the register of the next bus read or write
// - the first byte after the address of every write loads the pointer
// - reset clears the pointer so the first read gives the local high byte
// - local high byte at 00; low bits at 10 bits 7..4, not-valid in bit 1
// - first remote high byte at 01; its temperature resets to zero
// - first remote low byte at 11: fraction 7..4, not-valid bit 1, open bit 0
// - second remote channel at 02 and 12 exists only on the dual variant
// - a two-byte read from 00, 01 or 02 returns high then matching low byte
// - any write to 0F starts one conversion; data not stored; here only in shutdown with no conversion running
// - any write to FC resets the device; data ignored
// - standard range clamps below minus 64 to C0h and above 127 to 7Fh
// - a range change applies from the next conversion, not the running one
// - low-byte read right after its high-byte read returns the same conversion
// - shutdown bit stops conversions after the running sequence; clearing resumes
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

// ==========================================================
// register pointers
`define TSR_PTR_LOCAL_HIGH 8'h00
`define TSR_PTR_REM1_HIGH 8'h01
`define TSR_PTR_REM2_HIGH 8'h02
`define TSR_PTR_STATUS 8'h08
`define TSR_PTR_CFG1 8'h09
`define TSR_PTR_CFG2 8'h0A
`define TSR_PTR_RATE 8'h0B
`define TSR_PTR_BETA 8'h0C
`define TSR_PTR_ONE_SHOT 8'h0F
`define TSR_PTR_LOCAL_LOW 8'h10
`define TSR_PTR_REM1_LOW 8'h11
`define TSR_PTR_REM2_LOW 8'h12
`define TSR_PTR_NC1 8'h21
`define TSR_PTR_NC2 8'h22
`define TSR_PTR_SOFT_RESET 8'hFC
`define TSR_PTR_MAKER_ID 8'hFE
`define TSR_PTR_PART_ID 8'hFF
`define TSR_PTR_LOW_SEL 8'h10

// ==========================================================
// reset values and writable-bit masks
`define TSR_RST_ZERO 8'h00
`define TSR_RST_RATE 8'h07
`define TSR_RST_CFG2_SINGLE 8'h1C
`define TSR_RST_CFG2_DUAL 8'h3C
`define TSR_RST_BETA_SINGLE 8'h08
`define TSR_RST_BETA_DUAL 8'h88
`define TSR_MASK_CFG1 8'h44
`define TSR_MASK_CFG2_SINGLE 8'h1C
`define TSR_MASK_CFG2_DUAL 8'h3C
`define TSR_MASK_RATE 8'h07
`define TSR_MASK_BETA_SINGLE 8'h0F
`define TSR_MASK_BETA_DUAL 8'hFF

// ==========================================================
// field positions
`define TSR_BIT_SHUTDOWN 6
`define TSR_BIT_RANGE 2
`define TSR_BIT_NOT_VALID 1
`define TSR_BIT_OPEN 0

// ==========================================================
// temperature arithmetic in sixteenths of a degree
`define TSR_EXT_OFFSET 17'sh00400
`define TSR_STD_MIN 17'sh1FC00
`define TSR_STD_MAX 17'sh007FF
`define TSR_EXT_MIN 17'sh00000
`define TSR_EXT_MAX 17'sh00FFF

// ==========================================================
// channel codes and serial bus bits
`define TSR_CH_LOCAL 2'h0
`define TSR_CH_REM1 2'h1
`define TSR_CH_REM2 2'h2
`define TSR_LAST_BIT 3'h7

`endif

// ### test/tsr_register_map_props.sv
`timescale 1ns/1ps
// ==========
// port checker
module tsr_props_chk #(
  parameter DUAL = 1
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // bus pins
  input wire scl_in,
  input wire sda_oe,
  // converter side
  input wire conv_busy,
  input wire shutdown_request_bit,
  input wire range_extended,
  input wire [7:0] channel_enable_cfg,
  input wire [7:0] conv_rate,
  input wire [7:0] ideality_1,
  input wire one_shot_pulse,
  input wire soft_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // data may only move while the bus clock is low, so a high run must see it steady
  sequence scl_high_run;
    scl_in [*4];
  endsequence
  sequence lone_one;
    one_shot_pulse ##1 !one_shot_pulse;
  endsequence
  sequence lone_soft;
    soft_reset_pulse ##1 !soft_reset_pulse;
  endsequence
  sda_steady_a: assert property (scl_high_run |-> $stable(sda_oe))
    else $error("data line moved while bus clock high");
  one_pulse_a: assert property (one_shot_pulse |-> lone_one)
    else $error("one-shot pulse not single");
  one_gate_a: assert property (one_shot_pulse |-> shutdown_request_bit && !$past(conv_busy))
    else $error("one-shot outside idle shutdown");
  soft_pulse_a: assert property (soft_reset_pulse |-> lone_soft)
    else $error("soft reset pulse not single");
  soft_clear_a: assert property (soft_reset_pulse |-> ##[0:2]
    (conv_rate == 8'h07 && !shutdown_request_bit && ideality_1 == 8'h00))
    else $error("soft reset left registers set");
  range_hold_a: assert property ($changed(range_extended) |-> ($past(conv_busy) &&
    !$past(conv_busy, 2)) || $past(soft_reset_pulse) || $past(soft_reset_pulse, 2))
    else $error("range changed outside conversion start");
  rate_mask_a: assert property (conv_rate[7:3] == 5'h00)
    else $error("rate fixed-zero bits set");
  cfg2_mask_a: assert property ((channel_enable_cfg & ~(DUAL ? 8'h3C : 8'h1C)) == 8'h00)
    else $error("channel config fixed-zero bits set");
endmodule

bind tsr_register_map tsr_props_chk #(.DUAL(DUAL)) props (.clk(clk), .rstn(rstn),
  .scl_in(scl_in), .sda_oe(sda_oe), .conv_busy(conv_busy),
  .shutdown_request_bit(shutdown_request_bit), .range_extended(range_extended),
  .channel_enable_cfg(channel_enable_cfg), .conv_rate(conv_rate),
  .ideality_1(ideality_1), .one_shot_pulse(one_shot_pulse),
  .soft_reset_pulse(soft_reset_pulse));

// ### test/tsr_bus_host.sv
`timescale 1ns/1ps
// ==========
// two-wire bus host, 80 ns bit period
module tsr_bus_host #(
  parameter [6:0] DEV_ADDR = 7'h4C
) (
  // clock
  input wire clk,
  // bus; sda_pull high pulls the data line low
  output reg scl,
  output reg sda_pull,
  input wire sda,
  // one-clock strobe per byte read
  output reg rd_valid,
  output reg [7:0] rd_byte
);
  integer nacks;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
    nacks = 0;
  end
  // quarter bit time
  task q;
    repeat (4) @(posedge clk);
  endtask
  task bit_w(input b);
    begin
      sda_pull <= !b;
      q;
      scl <= 1'b1;
      q;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
  // sampled mid-high, the line long settled
  task bit_r(output b);
    begin
      sda_pull <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      b = sda;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
  task byte_w(input [7:0] v);
    integer k;
    reg a;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_w(v[k]);
      bit_r(a);
      if (a)
        nacks = nacks + 1;
    end
  endtask
  // pointer always set before a read, data byte optional
  task wr(input [7:0] p, input [7:0] v, input has_v);
    begin
      sda_pull <= 1'b1;
      q;
      scl <= 1'b0;
      q;
      byte_w({DEV_ADDR, 1'b0});
      byte_w(p);
      if (has_v)
        byte_w(v);
      sda_pull <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_pull <= 1'b0;
      q;
      q;
    end
  endtask
  task rd(input integer n);
    integer j;
    integer k;
    reg b;
    reg [7:0] v;
    begin
      sda_pull <= 1'b1;
      q;
      scl <= 1'b0;
      q;
      byte_w({DEV_ADDR, 1'b1});
      for (j = 0; j < n; j = j + 1) begin
        for (k = 0; k < 8; k = k + 1) begin
          bit_r(b);
          v = {v[6:0], b};
        end
        rd_byte <= v;
        rd_valid <= 1'b1;
        @(posedge clk);
        rd_valid <= 1'b0;
        bit_w(j == n - 1);
      end
      sda_pull <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_pull <= 1'b0;
      q;
      q;
    end
  endtask
endmodule

// ### test/test_tsr_register_map.sv
`timescale 1ns/1ps
// ==========
// bench top
module test_tsr_register_map;
  reg clk;
  reg rstn;
  reg conv_busy;
  reg result_valid;
  reg [1:0] result_chan;
  reg signed [15:0] result_temp;
  reg nv_flag;
  reg open_flag;
  wire scl;
  wire host_pull;
  wire sda_out;
  wire sda_oe;
  wire rd_valid;
  wire [7:0] rd_byte;
  wire shut;
  wire rng;
  wire [7:0] cfg2;
  wire [7:0] rate;
  wire [7:0] beta;
  wire [7:0] nc1;
  wire [7:0] nc2;
  wire one_p;
  wire soft_p;
  integer n_fail;
  integer checks_done;
  integer cycles;
  integer seed;
  integer n_one;
  integer n_soft;
  integer i;
  integer t;
  reg [1:0] ch;
  reg [7:0] d;
  reg [7:0] exp_q[$];
  reg [15:0] ptab[0:5];
  // open-drain data line with pull-up
  wire sda = !(host_pull || (sda_oe && !sda_out));
  tsr_register_map #(.MAKER_ID(8'h3E), .PART_ID(8'h6B)) dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .conv_busy(conv_busy), .result_valid(result_valid), .result_chan(result_chan),
    .result_temp(result_temp), .result_not_valid_flag(nv_flag), .result_open_flag(open_flag),
    .shutdown_request_bit(shut), .range_extended(rng), .channel_enable_cfg(cfg2),
    .conv_rate(rate), .beta_range(beta), .ideality_1(nc1), .ideality_2(nc2),
    .one_shot_pulse(one_p), .soft_reset_pulse(soft_p));
  tsr_bus_host host (.clk(clk), .scl(scl), .sda_pull(host_pull), .sda(sda),
    .rd_valid(rd_valid), .rd_byte(rd_byte));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task check_byte(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check_out(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: port %h expected %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // read bytes meet the oldest note; pulses counted; hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (one_p === 1'b1)
      n_one = n_one + 1;
    if (soft_p === 1'b1)
      n_soft = n_soft + 1;
    if (rd_valid === 1'b1 && exp_q.size() > 0)
      check_byte(rd_byte, exp_q.pop_front());
    if (cycles > 90000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  // clamped value in sixteenths, offset applied for the extended format
  function [15:0] enc(input integer tv, input ext);
    integer v;
    begin
      v = ext ? tv + 1024 : tv;
      if (v < (ext ? 0 : -1024))
        v = ext ? 0 : -1024;
      if (v > (ext ? 4095 : 2047))
        v = ext ? 4095 : 2047;
      enc = v[15:0];
    end
  endfunction
  task exp_temp(input [1:0] c, input integer tv, input ext);
    reg [15:0] e;
    begin
      e = enc(tv, ext);
      exp_q.push_back(e[11:4]);
      exp_q.push_back({e[3:0], 2'b00, nv_flag, open_flag && c != 2'h0});
    end
  endtask
  task post(input [1:0] c, input integer tv);
    begin
      @(posedge clk);
      d = $random(seed);
      conv_busy <= 1'b1;
      nv_flag <= d[0];
      open_flag <= d[1];
      @(posedge clk);
      result_valid <= 1'b1;
      result_chan <= c;
      result_temp <= tv[15:0];
      @(posedge clk);
      result_valid <= 1'b0;
      conv_busy <= 1'b0;
    end
  endtask
  task rd_at(input [7:0] p, input integer n);
    begin
      host.wr(p, 8'h00, 1'b0);
      host.rd(n);
    end
  endtask
  initial begin
    seed = 90;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    n_one = 0;
    n_soft = 0;
    rstn = 1'b0;
    conv_busy = 1'b0;
    result_valid = 1'b0;
    result_chan = 2'h0;
    result_temp = 16'h0000;
    nv_flag = 1'b0;
    open_flag = 1'b0;
    ptab[0] = 16'h0944;
    ptab[1] = 16'h0A3C;
    ptab[2] = 16'h0B07;
    ptab[3] = 16'h0CFF;
    ptab[4] = 16'h21FF;
    ptab[5] = 16'h22FF;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    exp_q.push_back(8'h00);
    host.rd(1);
    check_out(rate, 8'h07);
    check_out(cfg2, 8'h3C);
    check_out(beta, 8'h88);
    check_out({7'h00, shut}, 8'h00);
    // writable registers with fixed-zero bits masked off
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      host.wr(ptab[i][15:8], d, 1'b1);
      exp_q.push_back(d & ptab[i][7:0]);
      rd_at(ptab[i][15:8], 1);
    end
    check_out(nc2, d);
    host.wr(8'h09, 8'h00, 1'b1);
    host.wr(8'h00, 8'hA5, 1'b1);
    host.wr(8'h30, 8'h5C, 1'b1);
    exp_q.push_back(8'h00);
    rd_at(8'h00, 1);
    exp_q.push_back(8'h00);
    rd_at(8'h30, 1);
    exp_q.push_back(8'h3E);
    rd_at(8'hFE, 1);
    exp_q.push_back(8'h6B);
    rd_at(8'hFF, 1);
    conv_busy <= 1'b1;
    exp_q.push_back(8'h80);
    rd_at(8'h08, 1);
    conv_busy <= 1'b0;
    // every channel, both formats, clamps at both ends in standard and at the low end in extended
    for (i = 0; i < 12; i = i + 1) begin
      if (i == 6) begin
        conv_busy <= 1'b1;
        host.wr(8'h09, 8'h04, 1'b1);
        post(2'h1, 100);
        exp_temp(2'h1, 100, 1'b0);
        rd_at(8'h01, 2);
      end
      ch = i[1:0] % 2'h3;
      t = (i % 6 == 0) ? -3000 : (i % 6 == 1) ? 3000 : $random(seed) % 3000;
      post(ch, t);
      check_out({7'h00, rng}, {7'h00, i >= 6});
      exp_temp(ch, t, i >= 6);
      rd_at({6'h00, ch}, 2);
    end
    // a new result in mid-read must not split the pair
    post(2'h0, 321);
    exp_temp(2'h0, 321, 1'b1);
    host.wr(8'h00, 8'h00, 1'b0);
    fork
      host.rd(2);
      begin
        repeat (200) @(posedge clk);
        post(2'h0, -500);
      end
    join
    host.wr(8'h0F, 8'h00, 1'b1);
    check_out(n_one[7:0], 8'h00);
    host.wr(8'h09, 8'h40, 1'b1);
    host.wr(8'h0F, 8'h77, 1'b1);
    check_out(n_one[7:0], 8'h01);
    conv_busy <= 1'b1;
    host.wr(8'h0F, 8'h00, 1'b1);
    conv_busy <= 1'b0;
    check_out(n_one[7:0], 8'h01);
    exp_q.push_back(8'h40);
    rd_at(8'h09, 1);
    host.wr(8'hFC, 8'h00, 1'b1);
    check_out(n_soft[7:0], 8'h01);
    check_out(rate, 8'h07);
    exp_q.push_back(8'h00);
    host.rd(1);
    check_out(exp_q.size(), 8'h00);
    check_out(host.nacks[7:0], 8'h00);
    results;
  end
endmodule
